// >>> uc0_control_status.sv
// Serial port 0 control/status register with completion flags and mode 0 rate
`timescale 1ns/1ps
`include "uc0_params.svh"
module uc0_control_status (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Special function register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrRdEn,
   output logic [7:0] sfrRdData,
   // Events from the shifter datapath
   input wire logic txEighthEnd,
   input wire logic txStopBegin,
   input wire logic rxFrameEnd,
   input wire logic rxStopBit,
   input wire logic rxNinthBit,
   // Receive pin
   input wire logic rxPin,
   // Control outputs
   output uc0_pkg::uc0_mode_type opMode,
   output logic rxEnableOut,
   output logic txNinthBitOut,
   output logic rxLineGated,
   output logic shiftTick,
   output logic serialIrq
);
   import uc0_pkg::*;

   typedef struct packed {
      uc0_ctrl_type ctrl;
      logic [7:0] rdData;
      logic rxSync1;
      logic rxSync2;
      logic rxLine;
      uc0_mode_type modeOut;
      logic renOut;
      logic tb8Out;
      logic tick;
      logic irq;
      logic [4:0] quietCnt;
   } uc0_state_type;

   localparam uc0_state_type RESET_STATE = '{
      ctrl: `UC0_CTRL_RESET,
      rdData: `UC0_READ_IDLE,
      rxSync1: 1'b1,
      rxSync2: 1'b1,
      rxLine: 1'b1,
      modeOut: UC0_MODE0,
      renOut: 1'b0,
      tb8Out: 1'b0,
      tick: 1'b0,
      irq: 1'b0,
      quietCnt: 5'h00
   };

   uc0_state_type st_reg;
   uc0_state_type st_next;
   logic wrHit;
   logic rdHit;
   logic rxAccepted;
   logic divTick;

   // Mode 0 rate divider, stopped outside mode 0
   uc0_rate_div #(
      .CNT_W(`UC0_DIV_CNT_W)
   ) uc0_rate_div_inst (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(st_reg.ctrl.mode == UC0_MODE0),
      .fastSel(st_reg.ctrl.rateSel),
      .tick(divTick)
   );

   // Next state; hardware sets are applied after the CPU write so a set wins over a clear
   always_comb
   begin
      st_next = st_reg;
      wrHit = sfrWrEn && (sfrAddr == `UC0_CTRL_ADDR); // RULE1
      rdHit = sfrRdEn && (sfrAddr == `UC0_CTRL_ADDR); // RULE1
      rxAccepted = rxFrameEnd && st_reg.ctrl.rxEnable; // RULE6
      if (wrHit)
      begin
         st_next.ctrl = uc0_ctrl_type'(sfrWrData); // RULE15 RULE11 RULE13
      end
      // Receive completion depends on the mode in force when the frame ends
      if (rxAccepted)
      begin
         unique case (st_reg.ctrl.mode) // RULE2
            UC0_MODE0:
            begin
               st_next.ctrl.rxDone = 1'b1; // RULE13
            end
            UC0_MODE1:
            begin
               st_next.ctrl.rxNinth = rxStopBit; // RULE8
               if (!st_reg.ctrl.rateSel || rxStopBit) // RULE4 RULE5
               begin
                  st_next.ctrl.rxDone = 1'b1; // RULE13
               end
            end
            UC0_MODE2, UC0_MODE3:
            begin
               st_next.ctrl.rxNinth = rxNinthBit; // RULE8
               st_next.ctrl.rxDone = 1'b1; // RULE13
            end
         endcase
      end
      // Transmit completion point moves with the frame format
      if (st_reg.ctrl.mode == UC0_MODE0)
      begin
         if (txEighthEnd)
         begin
            st_next.ctrl.txDone = 1'b1; // RULE9
         end
      end
      else if (txStopBegin)
      begin
         st_next.ctrl.txDone = 1'b1; // RULE10
      end
      // Read data answers one cycle later; unaddressed reads return zero
      st_next.rdData = rdHit ? st_reg.ctrl : `UC0_READ_IDLE; // RULE1
      // Receive pin synchroniser, then idle-high unless reception is enabled
      st_next.rxSync1 = rxPin;
      st_next.rxSync2 = st_reg.rxSync1;
      st_next.rxLine = st_reg.ctrl.rxEnable ? st_reg.rxSync2 : 1'b1; // RULE6
      // Outputs other than the shift tick track the register as it will stand next cycle
      st_next.modeOut = st_next.ctrl.mode; // RULE2
      st_next.renOut = st_next.ctrl.rxEnable;
      st_next.tb8Out = st_next.ctrl.txNinth; // RULE7
      st_next.tick = divTick; // RULE3 RULE12
      st_next.irq = st_next.ctrl.txDone || st_next.ctrl.rxDone; // RULE14
      // Saturating count of cycles since a register write; lets rate checks skip reconfiguration
      if (wrHit)
      begin
         st_next.quietCnt = 5'h00;
      end
      else if (st_reg.quietCnt != 5'h1F)
      begin
         st_next.quietCnt = st_reg.quietCnt + 5'h01;
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st_reg <= RESET_STATE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sfrRdData = st_reg.rdData;
   assign opMode = st_reg.modeOut;
   assign rxEnableOut = st_reg.renOut;
   assign txNinthBitOut = st_reg.tb8Out;
   assign rxLineGated = st_reg.rxLine;
   assign shiftTick = st_reg.tick;
   assign serialIrq = st_reg.irq;

   property p_read;
      @(posedge sys_clk) disable iff (srst)
      (sfrRdEn && sfrAddr == `UC0_CTRL_ADDR) |=> (sfrRdData == $past(st_reg.ctrl));
   endproperty
   a_read: assert property (p_read) else $error("read data does not match register"); // RULE1

   property p_mode;
      @(posedge sys_clk) disable iff (srst)
      (sfrWrEn && sfrAddr == `UC0_CTRL_ADDR) |=> (opMode == uc0_mode_type'($past(sfrWrData[7:6])));
   endproperty
   a_mode: assert property (p_mode) else $error("mode output ignores write"); // RULE2

   property p_slow;
      @(posedge sys_clk) disable iff (srst)
      (shiftTick && opMode == UC0_MODE0 && !st_reg.ctrl.rateSel && st_reg.quietCnt >= 5'h06)
         |-> ##12 (shiftTick || st_reg.quietCnt < 5'h0D);
   endproperty
   a_slow: assert property (p_slow) else $error("slow shift period is not 12"); // RULE3

   property p_fast;
      @(posedge sys_clk) disable iff (srst)
      (shiftTick && opMode == UC0_MODE0 && st_reg.ctrl.rateSel && st_reg.quietCnt >= 5'h06)
         |=> (!shiftTick || st_reg.quietCnt < 5'h02)[*3] ##1 (shiftTick || st_reg.quietCnt < 5'h05);
   endproperty
   a_fast: assert property (p_fast) else $error("fast shift period is not 4"); // RULE12

   property p_stop_filter;
      @(posedge sys_clk) disable iff (srst)
      (rxFrameEnd && st_reg.ctrl.rxEnable && st_reg.ctrl.mode == UC0_MODE1 && st_reg.ctrl.rateSel
         && !rxStopBit && !st_reg.ctrl.rxDone && !sfrWrEn) |=> !st_reg.ctrl.rxDone;
   endproperty
   a_stop_filter: assert property (p_stop_filter) else $error("low stop bit flagged"); // RULE4

   property p_rx_any;
      @(posedge sys_clk) disable iff (srst)
      (rxFrameEnd && st_reg.ctrl.rxEnable && st_reg.ctrl.mode == UC0_MODE1 && !st_reg.ctrl.rateSel)
         |=> (st_reg.ctrl.rxDone && serialIrq);
   endproperty
   a_rx_any: assert property (p_rx_any) else $error("frame end not flagged"); // RULE5

   property p_rx_off;
      @(posedge sys_clk) disable iff (srst)
      (!st_reg.ctrl.rxEnable && !sfrWrEn) |=> ($stable(st_reg.ctrl.rxDone) && $stable(st_reg.ctrl.rxNinth)
         && rxLineGated);
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receive acted while disabled"); // RULE6

   property p_tb8;
      @(posedge sys_clk) disable iff (srst)
      (sfrWrEn && sfrAddr == `UC0_CTRL_ADDR) |=> (txNinthBitOut == $past(sfrWrData[3]));
   endproperty
   a_tb8: assert property (p_tb8) else $error("ninth transmit bit wrong"); // RULE7

   property p_rb8;
      @(posedge sys_clk) disable iff (srst)
      (rxFrameEnd && st_reg.ctrl.rxEnable && st_reg.ctrl.mode != UC0_MODE0)
         |=> (st_reg.ctrl.rxNinth == ($past(st_reg.ctrl.mode) == UC0_MODE1 ? $past(rxStopBit) : $past(rxNinthBit)));
   endproperty
   a_rb8: assert property (p_rb8) else $error("received ninth bit not loaded"); // RULE8

   property p_tx_m0;
      @(posedge sys_clk) disable iff (srst)
      (txEighthEnd && st_reg.ctrl.mode == UC0_MODE0) |=> st_reg.ctrl.txDone;
   endproperty
   a_tx_m0: assert property (p_tx_m0) else $error("mode 0 transmit flag not set"); // RULE9

   property p_tx_stop;
      @(posedge sys_clk) disable iff (srst)
      (txStopBegin && st_reg.ctrl.mode != UC0_MODE0) |=> st_reg.ctrl.txDone;
   endproperty
   a_tx_stop: assert property (p_tx_stop) else $error("stop-time transmit flag not set"); // RULE10

   property p_flags_hold;
      @(posedge sys_clk) disable iff (srst)
      (st_reg.ctrl.txDone && !wrHit) |=> st_reg.ctrl.txDone;
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("transmit flag cleared by hardware"); // RULE11

   property p_rx_hold;
      @(posedge sys_clk) disable iff (srst)
      (st_reg.ctrl.rxDone && !wrHit) |=> st_reg.ctrl.rxDone;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive flag cleared by hardware"); // RULE13

   property p_irq;
      @(posedge sys_clk) disable iff (srst)
      serialIrq == (st_reg.ctrl.txDone || st_reg.ctrl.rxDone);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request disagrees with flags"); // RULE14

   property p_write_all;
      @(posedge sys_clk) disable iff (srst)
      (wrHit && !rxFrameEnd && !txEighthEnd && !txStopBegin) |=> (st_reg.ctrl == $past(sfrWrData));
   endproperty
   a_write_all: assert property (p_write_all) else $error("write did not load all bits"); // RULE15
endmodule

// >>> uc0_control_status_bench.sv
// Self-checking bench for the serial port 0 control/status block
`timescale 1ns/1ps
module uc0_control_status_bench;
   import uc0_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, rv, ev, lf = 8'h0B;
   logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, go = 1'b0, stopVal = 1'b0, ninthVal = 1'b0, pinVal = 1'b1;
   logic [1:0] kind = 2'h0;
   logic txEighthEnd, txStopBegin, rxFrameEnd, rxStopBit, rxNinthBit, rxPin;
   logic rxEnableOut, txNinthBitOut, rxLineGated, shiftTick, serialIrq;
   uc0_mode_type opMode;
   int err_total = 0, check_count = 0, cyc = 0, gap;
   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;
   uc0_control_status uc0_control_status_inst (.sys_clk(sys_clk), .srst(srst), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
      .txEighthEnd(txEighthEnd), .txStopBegin(txStopBegin), .rxFrameEnd(rxFrameEnd),
      .rxStopBit(rxStopBit), .rxNinthBit(rxNinthBit), .rxPin(rxPin), .opMode(opMode),
      .rxEnableOut(rxEnableOut), .txNinthBitOut(txNinthBitOut), .rxLineGated(rxLineGated),
      .shiftTick(shiftTick), .serialIrq(serialIrq));
   uc0_shifter_model uc0_shifter_model_inst (.go(go), .kind(kind), .stopVal(stopVal),
      .ninthVal(ninthVal), .pinVal(pinVal), .txEighthEnd(txEighthEnd), .txStopBegin(txStopBegin),
      .rxFrameEnd(rxFrameEnd), .rxStopBit(rxStopBit), .rxNinthBit(rxNinthBit), .rxPin(rxPin));
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, far above the roughly 650 cycles the tests need
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   // Register value after one shifter event, worked out from the field rules
   function automatic logic [7:0] expect_reg(input logic [7:0] r, input int k, input logic s, input logic n);
      logic [7:0] e;
      e = r;
      if (k == 0 && r[7:6] == 2'h0)
         e[1] = 1'b1;
      if (k == 1 && r[7:6] != 2'h0)
         e[1] = 1'b1;
      if (k == 2 && r[4])
      begin
         if (r[7:6] != 2'h0)
            e[2] = (r[7:6] == 2'h1) ? s : n;
         if (!(r[7:6] == 2'h1 && r[5] && !s))
            e[0] = 1'b1;
      end
      return e;
   endfunction
   // Bus cycles: strobe raised at a falling edge, dropped at the next
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(negedge sys_clk);
      sfrWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfrAddr = a;
      sfrRdEn = 1'b1;
      @(negedge sys_clk);
      sfrRdEn = 1'b0;
      d = sfrRdData;
   endtask
   // One shifter event pulse lasting a single cycle
   task automatic evt(input logic [1:0] k, input logic s, input logic n);
      @(negedge sys_clk);
      go = 1'b1;
      kind = k;
      stopVal = s;
      ninthVal = n;
      @(negedge sys_clk);
      go = 1'b0;
   endtask
   // Cycles between two shift ticks, bounded
   task automatic tick_gap(output int n);
      int w;
      w = 0;
      while (shiftTick !== 1'b1 && w < 40)
      begin
         @(negedge sys_clk);
         w++;
      end
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (shiftTick !== 1'b1 && n < 40);
   endtask
   initial
   begin
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      // Reset state and map decode
      rd(8'h98, rv);
      chk(rv, 8'h00);
      chk({6'h0, rxLineGated, serialIrq}, 8'h02);
      wr(8'h99, 8'hFF);
      rd(8'h99, rv);
      chk(rv, 8'h00);
      rd(8'h98, rv);
      chk(rv, 8'h00);
      $display("test map done");
      // Every mode, random fields, software-set flags
      for (int i = 0; i < 16; i++)
      begin
         lf = lfsr(lf);
         ev = {i[1:0], lf[5:0]};
         wr(8'h98, ev);
         rd(8'h98, rv);
         chk(rv, ev);
         chk({6'h0, opMode}, {6'h0, ev[7:6]});
         chk({5'h0, rxEnableOut, txNinthBitOut, serialIrq}, {5'h0, ev[4:3], ev[1] | ev[0]});
      end
      $display("test fields done");
      // Each event kind in each mode, random enable, rate bit and received bits
      for (int i = 0; i < 48; i++)
      begin
         lf = lfsr(lf);
         ev = {i[1:0], lf[5:2], 2'b00};
         wr(8'h98, ev);
         evt(2'(i % 3), lf[0], lf[1]);
         ev = expect_reg(ev, i % 3, lf[0], lf[1]);
         repeat (4) @(negedge sys_clk);
         rd(8'h98, rv);
         chk(rv, ev);
         chk({7'h0, serialIrq}, {7'h0, ev[1] | ev[0]});
      end
      $display("test events done");
      // Corner cases: mode 1 stop filter, set beating a clear, disabled receiver
      wr(8'h98, 8'h70);
      evt(2'h2, 1'b0, 1'b1);
      rd(8'h98, rv);
      chk(rv, 8'h70);
      evt(2'h2, 1'b1, 1'b0);
      rd(8'h98, rv);
      chk(rv, 8'h75);
      @(negedge sys_clk);
      sfrAddr = 8'h98;
      sfrWrData = 8'h40;
      sfrWrEn = 1'b1;
      go = 1'b1;
      kind = 2'h1;
      @(negedge sys_clk);
      sfrWrEn = 1'b0;
      go = 1'b0;
      rd(8'h98, rv);
      chk(rv, 8'h42);
      evt(2'h2, 1'b1, 1'b1);
      rd(8'h98, rv);
      chk(rv, 8'h42);
      // No shift ticks outside mode 0
      gap = 0;
      repeat (30)
      begin
         @(negedge sys_clk);
         if (shiftTick === 1'b1)
            gap++;
      end
      chk(8'(gap), 8'h00);
      $display("test corners done");
      // Mode 0 shift rates
      wr(8'h98, 8'h00);
      tick_gap(gap);
      chk(8'(gap), 8'h0C);
      wr(8'h98, 8'h20);
      tick_gap(gap);
      chk(8'(gap), 8'h04);
      $display("test rate done");
      // Receive line gating
      wr(8'h98, 8'h10);
      pinVal = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk({7'h0, rxLineGated}, 8'h00);
      wr(8'h98, 8'h00);
      repeat (5) @(negedge sys_clk);
      chk({7'h0, rxLineGated}, 8'h01);
      $display("test line done");
      final_report();
   end
endmodule

// >>> uc0_params.svh
// Constants for the serial port 0 control/status block
//Contract
//RULE1: Control/status register sits at special function address 98 hex, read and write.
//RULE2: Bits 7 and 6 give the mode number, 00 to 11 for modes 0 to 3.
//RULE3: Mode 0 shifts at clock over 12 with bit 5 clear, faster with it set.
//RULE4: Mode 1 with bit 5 set flags reception only for a high stop bit.
//RULE5: Mode 1 with bit 5 clear flags reception at every frame end.
//RULE6: Frames are accepted only while receive enable is set; line ignored otherwise.
//RULE7: Modes 2 and 3 send bit 3 as the ninth data bit.
//RULE8: Bit 2 takes stop bit in mode 1, ninth bit in modes 2 and 3.
//RULE9: Mode 0 sets transmit-complete when the eighth bit time ends.
//RULE10: Modes 1 to 3 set transmit-complete as the stop bit time begins.
//RULE11: Transmit-complete is never cleared by hardware; software writes it zero.
//RULE12: Mode 0 with bit 5 set shifts at a quarter of the clock.
//RULE13: Receive-complete bit 0 set at frame end; only software clears it.
//RULE14: Interrupt request raised while either completion flag is set.
//RULE15: CPU writes update all eight bits, including both completion flags.
`ifndef UC0_PARAMS_SVH
`define UC0_PARAMS_SVH
`define UC0_CTRL_ADDR 8'h98
`define UC0_CTRL_RESET 8'h00
`define UC0_READ_IDLE 8'h00
`define UC0_DIV_SLOW 12
`define UC0_DIV_FAST 4
`define UC0_DIV_CNT_W 4
`endif

// >>> uc0_pkg.sv
// Types shared by the serial port 0 control/status block
package uc0_pkg;
   typedef enum logic [1:0] {
      UC0_MODE0 = 2'b00,
      UC0_MODE1 = 2'b01,
      UC0_MODE2 = 2'b10,
      UC0_MODE3 = 2'b11
   } uc0_mode_type;

   // Field layout of the control/status register, bit 7 first
   typedef struct packed {
      uc0_mode_type mode;
      logic rateSel;
      logic rxEnable;
      logic txNinth;
      logic rxNinth;
      logic txDone;
      logic rxDone;
   } uc0_ctrl_type;
endpackage

// >>> uc0_rate_div.sv
// Mode 0 shift rate divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`include "uc0_params.svh"
module uc0_rate_div #(
   parameter int CNT_W = `UC0_DIV_CNT_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control
   input wire logic run,
   input wire logic fastSel,
   // Enable pulse
   output logic tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic fastPrev;
      logic tick;
   } uc0_div_state_type;

   uc0_div_state_type div_reg;
   uc0_div_state_type div_next;
   logic [CNT_W-1:0] loadVal;

   // Reload value; a change of rate restarts the count so no short period leaks out
   always_comb
   begin
      loadVal = fastSel ? CNT_W'(`UC0_DIV_FAST - 1) : CNT_W'(`UC0_DIV_SLOW - 1); // RULE3 RULE12
      div_next = div_reg;
      div_next.tick = 1'b0;
      div_next.fastPrev = fastSel;
      if (!run || fastSel != div_reg.fastPrev)
      begin
         div_next.cnt = loadVal;
      end
      else if (div_reg.cnt == '0)
      begin
         div_next.cnt = loadVal;
         div_next.tick = 1'b1;
      end
      else
      begin
         div_next.cnt = div_reg.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         div_reg <= '0;
      end
      else
      begin
         div_reg <= div_next;
      end
   end

   assign tick = div_reg.tick;
endmodule

// >>> uc0_shifter_model.sv
// Behavioural shifter and serial line model facing the control/status block
`timescale 1ns/1ps
module uc0_shifter_model (
   // Commands from the bench
   input wire logic go,
   input wire logic [1:0] kind,
   input wire logic stopVal,
   input wire logic ninthVal,
   input wire logic pinVal,
   // Event pulses and line
   output logic txEighthEnd,
   output logic txStopBegin,
   output logic rxFrameEnd,
   output logic rxStopBit,
   output logic rxNinthBit,
   output logic rxPin
);
   // One-cycle frame events, each lasting as long as go
   assign txEighthEnd = go && kind == 2'h0;
   assign txStopBegin = go && kind == 2'h1;
   assign rxFrameEnd = go && kind == 2'h2;
   // Received bits are inverted outside their valid cycle, so a late capture reads wrong
   assign rxStopBit = rxFrameEnd ? stopVal : ~stopVal;
   assign rxNinthBit = rxFrameEnd ? ninthVal : ~ninthVal;
   // Serial line level
   assign rxPin = pinVal;
endmodule
